// ### rvs_regs.sv
// rail3/rail4 voltage, sleep and run control registers behind a two-wire serial target
// assumes SCL/SDA and sleep pins come from outside MCLK; SDA is open drain, resolved outside
//
// Behaviour
// - decay bit picks controlled ramp or free discharge
// - decay bits 7:1 are plain spare storage
// - voltage register bits 7:1 hold normal code
// - sleep register bits 7:1 hold sleep code
// - sleep enable low always selects normal code
// - sleep enable high, pin low selects sleep code
// - sleep pin choice is fixed, not register set
// - rail4 field 00 normal, 11 sleep on low pin
// - rail4 bit 1 selects forced fixed-frequency mode
// - rail4 bit 0 low turns the rail off
`timescale 1ns/1ps
`default_nettype none
module rvs_regs
  import rvs_pkg::*;
#(
  parameter logic R3_USES_PIN_B = 1'b0,
  parameter logic R4_USES_PIN_B = 1'b0
) (
  input  wire logic       MCLK,
  input  wire logic       SYS_RST,
  input  wire logic       CE,
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_N,
  input  wire logic       SLEEP_PIN_A,
  input  wire logic       SLEEP_PIN_B,
  output logic [6:0]      RAIL3_CODE,
  output logic            RAIL3_DECAY_SELECT,
  output logic            RAIL4_USE_SLEEP_CODE,
  output logic            RAIL4_FORCED_PWM,
  output logic            RAIL4_RUN
);

  rvs_state_t s;
  rvs_state_t n;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       wr_now;
  logic       pin3;
  logic       pin4;

  function automatic logic [7:0] rd_val(input rvs_state_t v, input logic [7:0] a);
    case (a)
      RVS_OFF_DECAY:  rd_val = v.decay;
      RVS_OFF_R3NORM: rd_val = {v.r3norm, 1'b0};
      RVS_OFF_R3SLP:  rd_val = {v.r3slp, v.r3en};
      RVS_OFF_R4CTL:  rd_val = {2'b00, v.r4};
      default:        rd_val = 8'h00;
    endcase
  endfunction : rd_val

  always_comb begin
    n = s;
    // first stage feeds only the second; a change counts once stages two and three agree
    n.sy0 = {SLEEP_PIN_B, SLEEP_PIN_A, SDA_IN, SCL};
    n.sy1 = s.sy0;
    n.sy2 = s.sy1;
    for (int i = 0; i < 4; i++) begin
      if (s.sy1[i] == s.sy2[i]) begin
        n.stab[i] = s.sy2[i];
      end
    end
    scl_rise = !s.stab[RVS_PIN_SCL] && n.stab[RVS_PIN_SCL];
    scl_fall = s.stab[RVS_PIN_SCL] && !n.stab[RVS_PIN_SCL];
    start_c  = s.stab[RVS_PIN_SCL] && n.stab[RVS_PIN_SCL]
               && s.stab[RVS_PIN_SDA] && !n.stab[RVS_PIN_SDA];
    stop_c   = s.stab[RVS_PIN_SCL] && n.stab[RVS_PIN_SCL]
               && !s.stab[RVS_PIN_SDA] && n.stab[RVS_PIN_SDA];
    wr_now   = CE && scl_fall && (s.st == RVS_WR) && (s.cnt == RVS_LAST_BIT);

    if (start_c) begin
      n.st  = RVS_ADDR;
      // the SCL fall that closes the START is not a data bit, so it must not count
      n.cnt = RVS_CNT_ARM;
      n.drv = 1'b0;
    end else if (stop_c) begin
      n.st  = RVS_IDLE;
      n.drv = 1'b0;
    end else if (scl_rise) begin
      if (s.cnt != RVS_ACK_SLOT && (s.st == RVS_ADDR || s.st == RVS_REG || s.st == RVS_WR)) begin
        n.sh = {s.sh[6:0], n.stab[RVS_PIN_SDA]};
      end
      // a not-acknowledge from the host ends a read burst
      if (s.st == RVS_RD && s.cnt == RVS_ACK_SLOT && n.stab[RVS_PIN_SDA]) begin
        n.st = RVS_IGN;
      end
    end else if (scl_fall) begin
      if (s.cnt == RVS_LAST_BIT) begin
        n.cnt = RVS_ACK_SLOT;
        unique case (s.st)
          RVS_ADDR: begin
            if (s.sh[7:1] == RVS_DEV_ADDR) begin
              n.drv = 1'b1;
            end else begin
              n.st = RVS_IGN;
            end
          end
          RVS_REG: n.drv = 1'b1;
          RVS_WR: begin
            n.drv = 1'b1;
            case (s.ptr)
              RVS_OFF_DECAY: n.decay = s.sh;
              RVS_OFF_R3NORM: n.r3norm = s.sh[7:1];
              RVS_OFF_R3SLP: begin
                n.r3slp = s.sh[7:1];
                n.r3en  = s.sh[0];
              end
              RVS_OFF_R4CTL: n.r4 = s.sh[5:0];
              default: n.r4 = s.r4;
            endcase
          end
          RVS_RD:   n.drv = 1'b0;
          RVS_IDLE, RVS_IGN: n.drv = 1'b0;
        endcase
      end else if (s.cnt == RVS_ACK_SLOT) begin
        n.cnt = 4'h0;
        n.drv = 1'b0;
        unique case (s.st)
          RVS_ADDR: begin
            if (s.sh[0]) begin
              n.st  = RVS_RD;
              n.rd  = rd_val(s, s.ptr);
              n.drv = !n.rd[7];
            end else begin
              n.st = RVS_REG;
            end
          end
          RVS_REG: begin
            n.ptr = s.sh;
            n.st  = RVS_WR;
          end
          RVS_WR: n.ptr = s.ptr + 8'h01;
          RVS_RD: begin
            n.ptr = s.ptr + 8'h01;
            n.rd  = rd_val(s, n.ptr);
            n.drv = !n.rd[7];
          end
          RVS_IDLE, RVS_IGN: n.drv = 1'b0;
        endcase
      end else begin
        n.cnt = s.cnt + 4'h1;
        if (s.st == RVS_RD) begin
          n.rd  = {s.rd[6:0], 1'b0};
          n.drv = !s.rd[6];
        end
      end
    end

    // the pin choice is a build-time strap so software can never move it
    pin3 = R3_USES_PIN_B ? n.stab[RVS_PIN_B] : n.stab[RVS_PIN_A];
    pin4 = R4_USES_PIN_B ? n.stab[RVS_PIN_B] : n.stab[RVS_PIN_A];
    n.o_code  = (n.r3en && !pin3) ? n.r3slp : n.r3norm;
    n.o_decay = n.decay[0];
    // reserved codes 01 and 10 are treated as disabled
    n.o_r4slp = (n.r4[RVS_R4_SLP_LSB +: 2] == 2'b11) && !pin4;
    n.o_r4pwm = n.r4[RVS_R4_MODE_BIT];
    n.o_r4run = n.r4[RVS_R4_RUN_BIT];
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s        <= '0;
      s.sy0    <= RVS_PIN_RST;
      s.sy1    <= RVS_PIN_RST;
      s.sy2    <= RVS_PIN_RST;
      s.stab   <= RVS_PIN_RST;
      s.st     <= RVS_IDLE;
      s.decay  <= {RVS_R3_NORM_RST, RVS_DECAY_RST};
      s.r3norm <= RVS_R3_NORM_RST;
      s.r3slp  <= RVS_R3_SLP_RST;
      s.r3en   <= RVS_R3_SLPEN_RST;
      s.r4     <= RVS_R4_RST;
      s.o_code <= RVS_R3_NORM_RST;
      s.o_decay <= RVS_DECAY_RST;
      s.o_r4pwm <= RVS_R4_RST[RVS_R4_MODE_BIT];
      s.o_r4run <= RVS_R4_RST[RVS_R4_RUN_BIT];
    end else if (CE) begin
      s <= n;
    end
  end

  assign SDA_OUT              = 1'b0;
  assign SDA_OE_N             = !s.drv;
  assign RAIL3_CODE           = s.o_code;
  assign RAIL3_DECAY_SELECT   = s.o_decay;
  assign RAIL4_USE_SLEEP_CODE = s.o_r4slp;
  assign RAIL4_FORCED_PWM     = s.o_r4pwm;
  assign RAIL4_RUN            = s.o_r4run;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  logic sel3_q;
  assign sel3_q = R3_USES_PIN_B ? s.stab[RVS_PIN_B] : s.stab[RVS_PIN_A];

  sequence s_write_to(logic [7:0] a);
    wr_now && s.ptr == a;
  endsequence

  property p_decay_follows;
    s_write_to(RVS_OFF_DECAY) |=> RAIL3_DECAY_SELECT == $past(s.sh[0]);
  endproperty
  a_decay_follows: assert property (p_decay_follows) else $error("decay select stale");

  property p_spare_store;
    s_write_to(RVS_OFF_DECAY) |=> s.decay == $past(s.sh);
  endproperty
  a_spare_store: assert property (p_spare_store) else $error("decay write lost");

  property p_norm_store;
    s_write_to(RVS_OFF_R3NORM) |=> s.r3norm == $past(s.sh[7:1]);
  endproperty
  a_norm_store: assert property (p_norm_store) else $error("normal code write lost");

  property p_sleep_code;
    (s.r3en && !sel3_q) |-> RAIL3_CODE == s.r3slp;
  endproperty
  a_sleep_code: assert property (p_sleep_code) else $error("sleep code not selected");

  property p_normal_code;
    (!s.r3en || sel3_q) |-> RAIL3_CODE == s.r3norm;
  endproperty
  a_normal_code: assert property (p_normal_code) else $error("normal code not selected");

  property p_r4_sleep_off;
    s.r4[RVS_R4_SLP_LSB +: 2] == 2'b00 |-> !RAIL4_USE_SLEEP_CODE;
  endproperty
  a_r4_sleep_off: assert property (p_r4_sleep_off) else $error("rail4 sleep while disabled");

  property p_r4_off;
    !s.r4[RVS_R4_RUN_BIT] |-> !RAIL4_RUN;
  endproperty
  a_r4_off: assert property (p_r4_off) else $error("rail4 runs while off");

  property p_write_effect;
    s_write_to(RVS_OFF_R4CTL) |=> RAIL4_RUN == $past(s.sh[0])
      && RAIL4_FORCED_PWM == $past(s.sh[1]);
  endproperty
  a_write_effect: assert property (p_write_effect) else $error("rail4 write late");

endmodule : rvs_regs
`default_nettype wire

// ### rvs_pkg.sv
// package for the rail3/rail4 voltage and sleep control register bank
// assumes a single clock domain; serial pins are synchronised inside the bank
package rvs_pkg;

  localparam logic [7:0] RVS_OFF_DECAY  = 8'h22;
  localparam logic [7:0] RVS_OFF_R3NORM = 8'h23;
  localparam logic [7:0] RVS_OFF_R3SLP  = 8'h24;
  localparam logic [7:0] RVS_OFF_R4CTL  = 8'h25;

  // serial bus target address, value arbitrary
  localparam logic [6:0] RVS_DEV_ADDR   = 7'h2a;

  localparam logic [6:0] RVS_R3_NORM_RST  = 7'h00;
  localparam logic [6:0] RVS_R3_SLP_RST   = 7'h00;
  localparam logic       RVS_R3_SLPEN_RST = 1'b0;
  localparam logic       RVS_DECAY_RST    = 1'b0;
  localparam logic [5:0] RVS_R4_RST       = 6'h0c;

  localparam int RVS_R4_RUN_BIT  = 0;
  localparam int RVS_R4_MODE_BIT = 1;
  localparam int RVS_R4_SLP_LSB  = 4;

  localparam int RVS_PIN_SCL = 0;
  localparam int RVS_PIN_SDA = 1;
  localparam int RVS_PIN_A   = 2;
  localparam int RVS_PIN_B   = 3;
  localparam logic [3:0] RVS_PIN_RST = 4'h3;

  // bit counter value armed by a START; the host's own SCL fall after START wraps it to zero
  localparam logic [3:0] RVS_CNT_ARM  = 4'hf;
  localparam logic [3:0] RVS_ACK_SLOT = 4'h8;
  localparam logic [3:0] RVS_LAST_BIT = 4'h7;

  typedef enum logic [5:0] {
    RVS_IDLE = 6'h01,
    RVS_ADDR = 6'h02,
    RVS_REG  = 6'h04,
    RVS_WR   = 6'h08,
    RVS_RD   = 6'h10,
    RVS_IGN  = 6'h20
  } rvs_st_t;

  typedef struct packed {
    logic [3:0] sy0;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] stab;
    rvs_st_t    st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [7:0] rd;
    logic       drv;
    logic [7:0] decay;
    logic [6:0] r3norm;
    logic [6:0] r3slp;
    logic       r3en;
    logic [5:0] r4;
    logic [6:0] o_code;
    logic       o_decay;
    logic       o_r4slp;
    logic       o_r4pwm;
    logic       o_r4run;
  } rvs_state_t;

endpackage : rvs_pkg

// ### rvs_host.sv
// host model for the two-wire serial bus of the rail register bank
// assumes the bench resolves SDA from both open-drain drivers with a pull-up
`timescale 1ns/1ps
`default_nettype none
module rvs_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_h
);
  initial begin
    scl   = 1'b1;
    sda_h = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w

  // data moves mid low phase, so it never changes while scl is high
  task automatic bitx(input logic b, output logic r);
    w(4);
    sda_h = b;
    w(4);
    scl = 1'b1;
    w(8);
    r = sda;
    scl = 1'b0;
  endtask : bitx

  task automatic xfer(input logic [7:0] d, input logic ak_in, output logic [7:0] q,
                      output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(ak_in, ak);
  endtask : xfer

  task automatic start();
    w(4);
    sda_h = 1'b1;
    w(4);
    scl = 1'b1;
    w(8);
    sda_h = 1'b0;
    w(8);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    w(4);
    sda_h = 1'b0;
    w(4);
    scl = 1'b1;
    w(8);
    sda_h = 1'b1;
    w(8);
  endtask : stop
endmodule : rvs_host
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the rail register bank
// assumes default factory pin choice (pin a) and the host model on the serial pins
`timescale 1ns/1ps
`default_nettype none
module tb_top import rvs_pkg::*;
  ;
  logic       mclk    = 1'b0;
  logic       sys_rst = 1'b1;
  logic       pin_a   = 1'b1;
  logic       pin_b   = 1'b1;
  logic       scl;
  logic       sda_h;
  logic       sda_out;
  logic       sda_oe_n;
  logic       r3_decay;
  logic       r4_slp;
  logic       r4_pwm;
  logic       r4_run;
  logic [6:0] r3_code;
  wire  logic sda = sda_h & (sda_oe_n | sda_out);
  int         bad_count = 0;
  int         cmp_count = 0;

  rvs_regs rvs_regs_i (.MCLK(mclk), .SYS_RST(sys_rst), .CE(1'b1), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .SLEEP_PIN_A(pin_a), .SLEEP_PIN_B(pin_b),
    .RAIL3_CODE(r3_code), .RAIL3_DECAY_SELECT(r3_decay), .RAIL4_USE_SLEEP_CODE(r4_slp),
    .RAIL4_FORCED_PWM(r4_pwm), .RAIL4_RUN(r4_run));
  rvs_host rvs_host_i (.clk(mclk), .sda(sda), .scl(scl), .sda_h(sda_h));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic       ak;
    rvs_host_i.xfer(d, 1'b1, q, ak);
    chk("ack", 8'h00, {7'h00, ak});
  endtask : send

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rvs_host_i.start();
    send({RVS_DEV_ADDR, 1'b0});
    send(a);
    send(d);
    rvs_host_i.stop();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic       ak;
    rvs_host_i.start();
    send({RVS_DEV_ADDR, 1'b0});
    send(a);
    rvs_host_i.start();
    send({RVS_DEV_ADDR, 1'b1});
    rvs_host_i.xfer(8'hff, 1'b1, q, ak);
    rvs_host_i.stop();
    chk("readback", e, q);
  endtask : rd

  // pins settle through the synchronisers before anything is judged
  task automatic pins(input logic a, input logic b);
    pin_a = a;
    pin_b = b;
    repeat (8) @(posedge mclk);
    #1;
  endtask : pins

  task automatic t_reset();
    logic [7:0] q;
    logic       ak;
    rd(RVS_OFF_DECAY, 8'h00);
    rd(RVS_OFF_R3SLP, 8'h00);
    rd(RVS_OFF_R4CTL, 8'h0c);
    rd(8'h30, 8'h00);
    chk("run", 8'h00, {7'h00, r4_run});
    rvs_host_i.start();
    rvs_host_i.xfer({~RVS_DEV_ADDR, 1'b0}, 1'b1, q, ak);
    rvs_host_i.stop();
    chk("nack", 8'h01, {7'h00, ak});
    $display("test reset done");
  endtask : t_reset

  task automatic t_rail3();
    wr(RVS_OFF_R3NORM, 8'h55);
    rd(RVS_OFF_R3NORM, 8'h54);
    chk("r3code", 8'h2a, {1'b0, r3_code});
    pins(1'b0, 1'b0);
    wr(RVS_OFF_R3SLP, 8'h22);
    chk("r3code", 8'h2a, {1'b0, r3_code});
    wr(RVS_OFF_R3SLP, 8'h23);
    chk("r3code", 8'h11, {1'b0, r3_code});
    pins(1'b1, 1'b0);
    chk("r3code", 8'h2a, {1'b0, r3_code});
    $display("test rail3 done");
  endtask : t_rail3

  task automatic t_decay();
    wr(RVS_OFF_DECAY, 8'ha5);
    rd(RVS_OFF_DECAY, 8'ha5);
    chk("decay", 8'h01, {7'h00, r3_decay});
    wr(RVS_OFF_DECAY, 8'h54);
    chk("decay", 8'h00, {7'h00, r3_decay});
    $display("test decay done");
  endtask : t_decay

  // rail4 writes keep bits 3:2 at 11 and the sleep field at 00 or 11
  task automatic t_rail4();
    pins(1'b0, 1'b1);
    wr(RVS_OFF_R4CTL, 8'hcf);
    rd(RVS_OFF_R4CTL, 8'h0f);
    chk("r4", 8'h06, {5'h00, r4_run, r4_pwm, r4_slp});
    wr(RVS_OFF_R4CTL, 8'h3f);
    chk("r4", 8'h07, {5'h00, r4_run, r4_pwm, r4_slp});
    pins(1'b1, 1'b0);
    chk("r4", 8'h06, {5'h00, r4_run, r4_pwm, r4_slp});
    wr(RVS_OFF_R4CTL, 8'h3e);
    chk("r4", 8'h02, {5'h00, r4_run, r4_pwm, r4_slp});
    $display("test rail4 done");
  endtask : t_rail4

  initial begin
    repeat (2) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    t_reset();
    t_rail3();
    t_decay();
    t_rail4();
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
